//--- hdl/ifm_defs.svh
// Contract
// - method setting never rewrites stored default allocation
// - settings 0-2: contacts proportional, forward/reverse limits
// - setting 3: direction, speed select A, B
// - settings 4-6: same direction and speed mapping
// - settings 7-9: proportional contact becomes method switch
// - setting A: proportional contact becomes zero clamp
// - setting B: proportional contact becomes pulse inhibit
// - default allocation readable via two allocation words
`ifndef IFM_DEFS_SVH
`define IFM_DEFS_SVH

// ==========================================================
// contact positions in the contact vector
`define IFM_PIN_COUNT        7
`define IFM_PIN_SERVO_ON     0
`define IFM_PIN_PROP         1
`define IFM_PIN_FWD_OT       2
`define IFM_PIN_REV_OT       3
`define IFM_PIN_ALARM_RESET_IN      4
`define IFM_PIN_FWD_TL       5
`define IFM_PIN_REV_TL       6

// ==========================================================
// contact polarity and idle level (overtravel contacts are active high)
`define IFM_ACTIVE_HIGH_MASK 7'h0c
`define IFM_IDLE_LEVEL       7'h73

// ==========================================================
// control method setting codes
`define IFM_SET_SPEED        4'h0
`define IFM_SET_POSITION     4'h1
`define IFM_SET_TORQUE       4'h2
`define IFM_SET_INT_SPEED    4'h3
`define IFM_SET_INT_SPD_SPD  4'h4
`define IFM_SET_INT_SPD_POS  4'h5
`define IFM_SET_INT_SPD_TRQ  4'h6
`define IFM_SET_POS_SPD      4'h7
`define IFM_SET_POS_TRQ      4'h8
`define IFM_SET_TRQ_SPD      4'h9
`define IFM_SET_ZERO_CLAMP   4'ha
`define IFM_SET_INHIBIT      4'hb

// ==========================================================
// stored factory allocation words
`define IFM_ALLOC_FIRST_RST  16'h2100
`define IFM_ALLOC_SECOND_RST 16'h6543

`endif

//--- hdl/ifm_pkg.sv
package ifm_pkg;

  // ==========================================================
  // meaning given to the three variable contacts
  typedef enum logic [2:0] {
    IFM_MAP_TORQUE_LIMIT,
    IFM_MAP_INTERNAL_SPEED,
    IFM_MAP_METHOD_SWITCH,
    IFM_MAP_ZERO_CLAMP,
    IFM_MAP_PULSE_INHIBIT
  } ifm_map_type;

endpackage : ifm_pkg

//--- hdl/ifm_contact_if.sv
`timescale 1ns/10ps

// ==========================================================
// raw contact levels in, filtered levels out
interface ifm_contact_if #(
  parameter int WIDTH = 7
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] level;

  modport filter (input raw, output level);
  modport user   (output raw, input level);
endinterface : ifm_contact_if

//--- hdl/ifm_contact_sync.sv
`timescale 1ns/10ps

// ==========================================================
// three-stage synchroniser, a bit changes once stages two and three agree
module ifm_contact_sync #(
  parameter int               WIDTH = 7,
  parameter logic [WIDTH-1:0] IDLE  = '0
) (
  input  wire logic   clock,
  input  wire logic   rst_n,
  ifm_contact_if.filter bus
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  // accept only bits whose last two samples match, rejecting one-sample glitches
  always_comb begin
    next_level = (stage2 & ~(stage2 ^ stage3)) | (level & (stage2 ^ stage3));
  end

  // stage1 feeds stage2 only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stage1 <= IDLE;
      stage2 <= IDLE;
      stage3 <= IDLE;
      level  <= IDLE;
    end else begin
      stage1 <= bus.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign bus.level = level;

endmodule // ifm_contact_sync

//--- hdl/ifm_input_mapper.sv
`timescale 1ns/10ps
`include "ifm_defs.svh"

module ifm_input_mapper #(
  parameter logic [15:0] ALLOC_FIRST  = `IFM_ALLOC_FIRST_RST,
  parameter logic [15:0] ALLOC_SECOND = `IFM_ALLOC_SECOND_RST
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [6:0]  contact_pin,
  input  wire logic [3:0]  control_method_setting,
  output logic             servo_on,
  output logic             forward_overtravel_in,
  output logic             reverse_overtravel_in,
  output logic             alarm_reset_in,
  output logic             proportional_operation_in,
  output logic             forward_torque_limit_in,
  output logic             reverse_torque_limit_in,
  output logic             rotation_direction_select,
  output logic             speed_select_a,
  output logic             speed_select_b,
  output logic             control_method_switch,
  output logic             zero_clamp_in,
  output logic             pulse_inhibit_in,
  output logic [15:0]      input_alloc_param_first,
  output logic [15:0]      input_alloc_param_second
);

  // ==========================================================
  // contact synchronisation
  logic [6:0]               active;
  ifm_pkg::ifm_map_type     map;
  ifm_contact_if #(.WIDTH(`IFM_PIN_COUNT)) contacts ();

  assign contacts.raw = contact_pin;

  ifm_contact_sync #(
    .WIDTH (`IFM_PIN_COUNT),
    .IDLE  (`IFM_IDLE_LEVEL)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .bus   (contacts)
  );

  // fold polarity so a set bit means the function is asserted
  assign active = ~(contacts.level ^ `IFM_ACTIVE_HIGH_MASK);

  // ==========================================================
  // mode decode
  // setting groups
  always_comb begin
    case (control_method_setting)
      `IFM_SET_SPEED, `IFM_SET_POSITION, `IFM_SET_TORQUE: begin
        map = ifm_pkg::IFM_MAP_TORQUE_LIMIT;
      end
      `IFM_SET_INT_SPEED, `IFM_SET_INT_SPD_SPD, `IFM_SET_INT_SPD_POS, `IFM_SET_INT_SPD_TRQ: begin
        map = ifm_pkg::IFM_MAP_INTERNAL_SPEED;
      end
      `IFM_SET_POS_SPD, `IFM_SET_POS_TRQ, `IFM_SET_TRQ_SPD: begin
        map = ifm_pkg::IFM_MAP_METHOD_SWITCH;
      end
      `IFM_SET_ZERO_CLAMP: begin
        map = ifm_pkg::IFM_MAP_ZERO_CLAMP;
      end
      `IFM_SET_INHIBIT: begin
        map = ifm_pkg::IFM_MAP_PULSE_INHIBIT;
      end
      // undefined codes fall back to the plain torque-limit meaning
      default: begin
        map = ifm_pkg::IFM_MAP_TORQUE_LIMIT;
      end
    endcase
  end

  // ==========================================================
  // function outputs
  logic next_servo_on;
  logic next_fwd_ot;
  logic next_rev_ot;
  logic next_alarm_reset_in;
  logic next_prop;
  logic next_fwd_tl;
  logic next_rev_tl;
  logic next_dir;
  logic next_speed_select_a;
  logic next_speed_select_b;
  logic next_switch;
  logic next_zero_clamp_in;
  logic next_inhibit;

  // functions not served by the current setting stay deasserted
  always_comb begin
    next_servo_on = active[`IFM_PIN_SERVO_ON];
    next_fwd_ot   = active[`IFM_PIN_FWD_OT];
    next_rev_ot   = active[`IFM_PIN_REV_OT];
    next_alarm_reset_in  = active[`IFM_PIN_ALARM_RESET_IN];
    next_prop     = 1'b0;
    next_fwd_tl   = 1'b0;
    next_rev_tl   = 1'b0;
    next_dir      = 1'b0;
    next_speed_select_a    = 1'b0;
    next_speed_select_b    = 1'b0;
    next_switch   = 1'b0;
    next_zero_clamp_in   = 1'b0;
    next_inhibit  = 1'b0;
    case (map)
      ifm_pkg::IFM_MAP_TORQUE_LIMIT: begin
        next_prop   = active[`IFM_PIN_PROP];
        next_fwd_tl = active[`IFM_PIN_FWD_TL];
        next_rev_tl = active[`IFM_PIN_REV_TL];
      end
      ifm_pkg::IFM_MAP_INTERNAL_SPEED: begin
        next_dir   = active[`IFM_PIN_PROP];
        next_speed_select_a = active[`IFM_PIN_FWD_TL];
        next_speed_select_b = active[`IFM_PIN_REV_TL];
      end
      ifm_pkg::IFM_MAP_METHOD_SWITCH: begin
        next_switch = active[`IFM_PIN_PROP];
        next_fwd_tl = active[`IFM_PIN_FWD_TL];
        next_rev_tl = active[`IFM_PIN_REV_TL];
      end
      ifm_pkg::IFM_MAP_ZERO_CLAMP: begin
        next_zero_clamp_in = active[`IFM_PIN_PROP];
        next_fwd_tl = active[`IFM_PIN_FWD_TL];
        next_rev_tl = active[`IFM_PIN_REV_TL];
      end
      ifm_pkg::IFM_MAP_PULSE_INHIBIT: begin
        next_inhibit = active[`IFM_PIN_PROP];
        next_fwd_tl  = active[`IFM_PIN_FWD_TL];
        next_rev_tl  = active[`IFM_PIN_REV_TL];
      end
      default: begin
        next_prop = 1'b0;
      end
    endcase
  end

  // outputs come from flops so a setting change never glitches them
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      servo_on                  <= 1'b0;
      forward_overtravel_in     <= 1'b0;
      reverse_overtravel_in     <= 1'b0;
      alarm_reset_in            <= 1'b0;
      proportional_operation_in <= 1'b0;
      forward_torque_limit_in   <= 1'b0;
      reverse_torque_limit_in   <= 1'b0;
      rotation_direction_select <= 1'b0;
      speed_select_a            <= 1'b0;
      speed_select_b            <= 1'b0;
      control_method_switch     <= 1'b0;
      zero_clamp_in             <= 1'b0;
      pulse_inhibit_in          <= 1'b0;
    end else begin
      servo_on                  <= next_servo_on;
      forward_overtravel_in     <= next_fwd_ot;
      reverse_overtravel_in     <= next_rev_ot;
      alarm_reset_in            <= next_alarm_reset_in;
      proportional_operation_in <= next_prop;
      forward_torque_limit_in   <= next_fwd_tl;
      reverse_torque_limit_in   <= next_rev_tl;
      rotation_direction_select <= next_dir;
      speed_select_a            <= next_speed_select_a;
      speed_select_b            <= next_speed_select_b;
      control_method_switch     <= next_switch;
      zero_clamp_in             <= next_zero_clamp_in;
      pulse_inhibit_in          <= next_inhibit;
    end
  end

  // ==========================================================
  // stored allocation words
  logic [15:0] next_alloc_first;
  logic [15:0] next_alloc_second;

  always_comb begin
    next_alloc_first  = ALLOC_FIRST;   // setting has no path into these
    next_alloc_second = ALLOC_SECOND;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      input_alloc_param_first  <= `IFM_ALLOC_FIRST_RST;
      input_alloc_param_second <= `IFM_ALLOC_SECOND_RST;
    end else begin
      input_alloc_param_first  <= next_alloc_first;
      input_alloc_param_second <= next_alloc_second;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  logic [3:0] set_q;
  logic [6:0] act_q;
  always_ff @(posedge clock) begin
    set_q <= control_method_setting;
    act_q <= active;
  end

  chk_fixed_servo_on: assert property (servo_on == act_q[`IFM_PIN_SERVO_ON])
    else $error("servo on does not follow its contact");
  chk_fixed_overtravel: assert property (
    forward_overtravel_in == act_q[`IFM_PIN_FWD_OT] && reverse_overtravel_in == act_q[`IFM_PIN_REV_OT]
    && alarm_reset_in == act_q[`IFM_PIN_ALARM_RESET_IN])
    else $error("fixed contact function wrong");
  chk_basic_limits: assert property ($past(rst_n) && set_q <= 4'h2 |->
    proportional_operation_in == act_q[`IFM_PIN_PROP] && forward_torque_limit_in == act_q[`IFM_PIN_FWD_TL]
    && reverse_torque_limit_in == act_q[`IFM_PIN_REV_TL] && !speed_select_a)
    else $error("basic setting mapping wrong");
  chk_internal_speed_three: assert property ($past(rst_n) && set_q == 4'h3 |->
    rotation_direction_select == act_q[`IFM_PIN_PROP] && speed_select_a == act_q[`IFM_PIN_FWD_TL]
    && speed_select_b == act_q[`IFM_PIN_REV_TL] && !proportional_operation_in && !forward_torque_limit_in)
    else $error("internal speed mapping wrong");
  chk_internal_speed_combo: assert property ($past(rst_n) && set_q inside {4'h4, 4'h5, 4'h6} |->
    speed_select_b == act_q[`IFM_PIN_REV_TL] && rotation_direction_select == act_q[`IFM_PIN_PROP]
    && !reverse_torque_limit_in)
    else $error("combined internal speed mapping wrong");
  chk_method_switch: assert property ($past(rst_n) && set_q inside {4'h7, 4'h8, 4'h9} |->
    control_method_switch == act_q[`IFM_PIN_PROP] && forward_torque_limit_in == act_q[`IFM_PIN_FWD_TL]
    && !proportional_operation_in)
    else $error("method switch mapping wrong");
  chk_zero_clamp: assert property ($past(rst_n) && set_q == 4'ha |->
    zero_clamp_in == act_q[`IFM_PIN_PROP] && reverse_torque_limit_in == act_q[`IFM_PIN_REV_TL]
    && !control_method_switch)
    else $error("zero clamp mapping wrong");
  chk_pulse_inhibit: assert property ($past(rst_n) && set_q == 4'hb |->
    pulse_inhibit_in == act_q[`IFM_PIN_PROP] && forward_torque_limit_in == act_q[`IFM_PIN_FWD_TL]
    && !zero_clamp_in)
    else $error("pulse inhibit mapping wrong");
  chk_alloc_stable: assert property ($changed(control_method_setting) |=>
    $stable(input_alloc_param_first) && $stable(input_alloc_param_second))
    else $error("allocation words moved with setting");
  chk_alloc_readback: assert property ($past(rst_n) |->
    input_alloc_param_first == ALLOC_FIRST && input_alloc_param_second == ALLOC_SECOND)
    else $error("allocation words not readable");

  cov_internal_speed: cover property (set_q == 4'h3 && speed_select_a && speed_select_b);
  cov_method_switch:  cover property (set_q == 4'h8 && control_method_switch);
  cov_zero_clamp:     cover property (set_q == 4'ha && zero_clamp_in);
  cov_setting_change: cover property ($changed(control_method_setting) ##1 servo_on);

endmodule // ifm_input_mapper

//--- test/ifm_contact_driver.sv
`timescale 1ns/10ps
`include "ifm_defs.svh"

// ==========================================================
// external controller model: asserts functions, drives each contact
// at its own polarity; registered so a change lands just after an edge
module ifm_contact_driver (
  input  wire logic       clock,
  input  wire logic [6:0] assert_func,
  output logic      [6:0] contact_pin
);
  // idle before the first edge so the synchroniser never sees unknowns
  initial contact_pin = `IFM_IDLE_LEVEL;

  // active-low contacts invert, overtravel contacts pass straight
  always @(posedge clock) begin
    contact_pin <= ~(assert_func ^ `IFM_ACTIVE_HIGH_MASK);
  end
endmodule // ifm_contact_driver

//--- test/input_function_mapper_tb.sv
`timescale 1ns/10ps
`include "ifm_defs.svh"

module input_function_mapper_tb;
  logic        clock;
  logic        rst_n;
  logic [6:0]  func;
  logic [3:0]  setting;
  logic [6:0]  contact_pin;
  logic [12:0] outs;
  logic [15:0] alloc_a;
  logic [15:0] alloc_b;
  int          miscompares;
  int          n_checks;

  // ==========================================================
  // clock, partner and design
  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  ifm_contact_driver i_drv (
    .clock       (clock),
    .assert_func (func),
    .contact_pin (contact_pin)
  );

  ifm_input_mapper i_dut (
    .clock                     (clock),
    .rst_n                     (rst_n),
    .contact_pin               (contact_pin),
    .control_method_setting    (setting),
    .servo_on                  (outs[12]),
    .forward_overtravel_in     (outs[11]),
    .reverse_overtravel_in     (outs[10]),
    .alarm_reset_in            (outs[9]),
    .proportional_operation_in (outs[8]),
    .forward_torque_limit_in   (outs[7]),
    .reverse_torque_limit_in   (outs[6]),
    .rotation_direction_select (outs[5]),
    .speed_select_a            (outs[4]),
    .speed_select_b            (outs[3]),
    .control_method_switch     (outs[2]),
    .zero_clamp_in             (outs[1]),
    .pulse_inhibit_in          (outs[0]),
    .input_alloc_param_first   (alloc_a),
    .input_alloc_param_second  (alloc_b)
  );

  // ==========================================================
  // reference: expected function outputs from asserted contacts
  // and setting; unserved functions read 0, codes c..f act as 0
  function automatic int model(input int a, input int s);
    int p;
    int f;
    int r;
    int v;
    p = (a >> 1) & 1;
    f = (a >> 5) & 1;
    r = (a >> 6) & 1;
    v = ((a & 1) << 12) | (((a >> 2) & 1) << 11) | (((a >> 3) & 1) << 10) | (((a >> 4) & 1) << 9);
    if (s >= 3 && s <= 6) begin
      v = v | (p << 5) | (f << 4) | (r << 3);
    end else begin
      v = v | (f << 7) | (r << 6);
      if (s >= 7 && s <= 9) v = v | (p << 2);
      else if (s == 10) v = v | (p << 1);
      else if (s == 11) v = v | p;
      else v = v | (p << 8);
    end
    return v;
  endfunction

  // ==========================================================
  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // drive contacts and setting, wait n edges, compare all functions
  task automatic apply(input int a, input int s, input int n);
    @(posedge clock);
    func    <= 7'(a);
    setting <= 4'(s);
    repeat (n) @(posedge clock);
    #1;
    check({3'h0, outs}, 16'(model(a, s)));
  endtask

  task automatic check_alloc();
    check(alloc_a, `IFM_ALLOC_FIRST_RST);
    check(alloc_b, `IFM_ALLOC_SECOND_RST);
  endtask

  // a hang ends the run as a failure
  initial begin
    #2_000_000;
    miscompares++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    int s;
    int b;
    int k;
    rst_n       = 1'b0;
    func        = 7'h00;
    setting     = 4'h0;
    miscompares = 0;
    n_checks    = 0;
    void'($urandom(40));
    repeat (2) @(posedge clock);
    // release on an edge; the first edge after it still sees idle contacts
    rst_n <= 1'b1;
    #1;
    check({3'h0, outs}, 16'h0000);
    check_alloc();
    @(posedge clock);
    #1;
    check({3'h0, outs}, 16'h0000);
    // every code, each contact alone, then random mixes
    for (s = 0; s < 16; s++) begin
      for (b = 0; b < 7; b++) apply(1 << b, s, 8);
      for (k = 0; k < 4; k++) apply($urandom & 32'h7f, s, 8);
      check_alloc();
    end
    // settle all contacts first, since the sweep below waits only one edge per setting
    apply(32'h7f, 0, 8);
    // setting flips under held contacts, remap one edge later
    for (s = 0; s < 12; s++) apply(32'h7f, s, 1);
    check_alloc();
    // one-cycle glitch on every contact is filtered out
    apply(0, 3, 8);
    @(posedge clock);
    func <= 7'h7f;
    @(posedge clock);
    func <= 7'h00;
    repeat (8) @(posedge clock);
    #1;
    check({3'h0, outs}, 16'h0000);
    // second reset with all contacts asserted clears functions
    apply(32'h7f, 10, 8);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    check({3'h0, outs}, 16'h0000);
    check_alloc();
    // synchroniser restarts from idle, so outputs stay clear one more edge
    @(posedge clock);
    #1;
    check({3'h0, outs}, 16'h0000);
    apply(32'h7f, 11, 8);
    wrap_up();
  end
endmodule // input_function_mapper_tb
